// >>> src/secl_loader.sv
// serial eeprom configuration loader with register bus slave
`timescale 1ns/1ps
module secl_loader
  import secl_pkg::*;
#(
  parameter int HALF_CYCLES = 4,
  parameter int LOCAL_WORDS = 32,
  parameter int CIS_WORDS   = 64
) (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          link_clock,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output secl_pins_t         ee_pins,
  input  wire logic          ee_do,
  output logic               loading,
  output secl_byte_wr_t      pci_cfg_wr,
  output secl_byte_wr_t      func_access
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] secl_next_zone(input logic [2:0] cur, input logic [4:0] mask);
    logic [2:0] z;
    z = SECL_ZONE_END;
    for (int i = 5; i >= 1; i--) begin
      if (i > int'(cur) && mask[5 - i]) begin
        z = 3'(i);
      end
    end
    return z;
  endfunction : secl_next_zone

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  secl_main_t   state;
  logic [9:0]   word_addr;
  logic [2:0]   zone;
  logic         sub;
  logic [4:0]   zone_mask;
  logic [15:0]  tuple_left;
  logic [15:0]  first_word;
  logic [5:0]   cis_ptr;
  logic         valid_prog;
  logic         req_tgl;
  logic         ack_meta;
  logic         ack_sync;
  logic         ack_seen;
  logic         do_m_meta;
  logic         do_m_sync;
  logic [5:0]   index;
  logic [31:0]  local_mem [0:LOCAL_WORDS-1];
  logic [9:0]   power_tab [0:15];
  logic [15:0]  cis_mem   [0:CIS_WORDS-1];
  logic [31:0]  read_data;
  logic         addr_ok;
  logic         apb_commit;
  logic         reload_req;
  logic [15:0]  word;
  logic         exec;
  logic [2:0]   after_zone;
  secl_result_t res;

  // link domain
  secl_link_t   lstate;
  logic         link_rst_meta;
  logic         link_rst;
  logic         req_meta;
  logic         req_sync;
  logic         req_seen;
  logic         busy_meta;
  logic         busy_sync;
  logic [2:0]   sw_meta;
  logic [2:0]   sw_sync;
  logic         do_meta;
  logic         do_sync;
  logic [7:0]   half_cnt;
  logic [3:0]   bit_idx;
  logic [9:0]   laddr;
  logic         detect;
  logic [15:0]  shift;
  logic         ack_tgl;
  secl_pins_t   eng;
  logic [3:0]   sent;

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  assign word       = res.data;
  assign exec       = (state == M_EXEC) && !res.absent;
  assign after_zone = secl_next_zone(zone, zone_mask);

  // ----------------------------------------------------------------
  // ack and memory data-out crossing into bus domain
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    ack_meta  <= ack_tgl;
    ack_sync  <= ack_meta;
    do_m_meta <= ee_do;
    do_m_sync <= do_m_meta;
  end

  // ----------------------------------------------------------------
  // download sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= M_REQ;
      word_addr  <= '0;
      zone       <= '0;
      sub        <= 1'b0;
      zone_mask  <= '0;
      tuple_left <= '0;
      first_word <= '0;
      cis_ptr    <= '0;
      valid_prog <= 1'b0;
      loading    <= 1'b1;
      req_tgl    <= 1'b0;
      ack_seen   <= 1'b0;
    end else if (reload_req) begin
      state      <= M_REQ;
      word_addr  <= '0;
      zone       <= '0;
      sub        <= 1'b0;
      valid_prog <= 1'b0;
      loading    <= 1'b1;
    end else begin
      unique case (state)
        M_REQ: begin
          req_tgl <= ~req_tgl;
          state   <= M_WAIT;
        end
        M_WAIT: begin
          if (ack_sync != ack_seen) begin
            ack_seen <= ack_sync;
            state    <= M_EXEC;
          end
        end
        M_EXEC: begin
          state     <= M_REQ;
          word_addr <= word_addr + 10'h1;
          if (res.absent) begin
            state <= M_DONE;
          end else begin
            unique case (zone)
              3'h0: begin
                if (word[15:8] != SECL_SIGNATURE) begin
                  state <= M_DONE;
                end else begin
                  valid_prog <= 1'b1;
                  zone_mask  <= word[4:0];
                  zone       <= secl_next_zone(3'h0, word[4:0]);
                  if (secl_next_zone(3'h0, word[4:0]) == SECL_ZONE_END) begin
                    state <= M_DONE;
                  end
                end
              end
              3'h1, 3'h2: begin
                if (!word[SECL_CONT_BIT]) begin
                  zone <= after_zone;
                  if (after_zone == SECL_ZONE_END) begin
                    state <= M_DONE;
                  end
                end
              end
              3'h3: begin
                if (!sub) begin
                  tuple_left <= word;
                  cis_ptr    <= '0;
                  sub        <= (word != 16'h0);
                  if (word == 16'h0) begin
                    zone <= after_zone;
                    if (after_zone == SECL_ZONE_END) begin
                      state <= M_DONE;
                    end
                  end
                end else begin
                  cis_ptr    <= cis_ptr + 6'h1;
                  tuple_left <= tuple_left - 16'h2;
                  if (tuple_left <= 16'h2) begin
                    sub  <= 1'b0;
                    zone <= after_zone;
                    if (after_zone == SECL_ZONE_END) begin
                      state <= M_DONE;
                    end
                  end
                end
              end
              3'h4: begin
                if (!sub && !word[SECL_CONT_BIT]) begin
                  zone <= after_zone;
                  if (after_zone == SECL_ZONE_END) begin
                    state <= M_DONE;
                  end
                end else begin
                  sub <= sub ? word[SECL_CONT_BIT] : 1'b1;
                end
              end
              3'h5: begin
                first_word <= word;
                sub        <= ~sub;
                if (sub && !word[SECL_CONT_BIT]) begin
                  state <= M_DONE;
                end
              end
              default: state <= M_DONE;
            endcase
          end
        end
        M_DONE: loading <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // zone writes towards other register spaces
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      pci_cfg_wr  <= '0;
      func_access <= '0;
    end else begin
      pci_cfg_wr.valid  <= exec && zone == 3'h4 && sub;
      pci_cfg_wr.wr     <= 1'b1;
      pci_cfg_wr.addr   <= {1'b0, word[14:8]};
      pci_cfg_wr.data   <= word[7:0];
      func_access.valid <= exec && zone == 3'h5 && sub;
      func_access.wr    <= first_word[SECL_FA_WRITE];
      func_access.addr  <= first_word[7:0];
      func_access.data  <= word[7:0];
    end
  end

  // ----------------------------------------------------------------
  // power data table and information structure ram
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        power_tab[i] <= '0;
      end
    end else if (exec && zone == 3'h1) begin
      power_tab[word[13:10]] <= word[9:0];
    end
  end

  always_ff @(posedge clock) begin
    if (exec && zone == 3'h3 && sub) begin
      cis_mem[cis_ptr] <= word;
    end
  end

  // ----------------------------------------------------------------
  // local register space
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < LOCAL_WORDS; i++) begin
        local_mem[i] <= '0;
      end
      local_mem[0] <= SECL_LCC_RESET;
    end else if (exec && zone == 3'h2) begin
      local_mem[word[14:10]][{word[9:8], 3'h0} +: 8] <= word[7:0];
    end else if (exec && zone == 3'h3 && !sub) begin
      local_mem[0][SECL_LCC_CIS_SRC] <= 1'b1;
    end else if (apb_commit && paddr < SECL_OFF_INDEX) begin
      local_mem[paddr[6:2]] <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  assign apb_commit = psel && penable && pready && pwrite && !pslverr;
  assign reload_req = apb_commit && paddr == SECL_OFF_LCC && pwdata[SECL_LCC_RELOAD];
  assign addr_ok    = paddr[1:0] == 2'h0 && paddr <= SECL_OFF_TABLE;

  always_comb begin
    read_data = local_mem[paddr[6:2]];
    if (paddr == SECL_OFF_LCC) begin
      read_data[SECL_LCC_RELOAD] = 1'b0;
      read_data[SECL_LCC_VALID]  = valid_prog;
      read_data[SECL_LCC_DO]     = do_m_sync;
    end else if (paddr == SECL_OFF_INDEX) begin
      read_data = {26'h0, index};
    end else if (paddr == SECL_OFF_TABLE) begin
      read_data = {cis_mem[index], 6'h0, power_tab[index[3:0]]};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= loading || !addr_ok;
        if (!pwrite && !loading && addr_ok) begin
          prdata <= read_data;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      index <= '0;
    end else if (apb_commit && paddr == SECL_OFF_INDEX) begin
      index <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // link domain synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    link_rst_meta <= reset;
    link_rst      <= link_rst_meta;
    req_meta      <= req_tgl;
    req_sync      <= req_meta;
    busy_meta     <= loading;
    busy_sync     <= busy_meta;
    sw_meta       <= local_mem[0][SECL_LCC_DI:SECL_LCC_SK];
    sw_sync       <= sw_meta;
    do_meta       <= ee_do;
    do_sync       <= do_meta;
  end

  // ----------------------------------------------------------------
  // serial read engine
  // ----------------------------------------------------------------
  assign sent = SECL_ADDR_MAX - bit_idx;

  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      lstate   <= L_IDLE;
      eng      <= '0;
      half_cnt <= '0;
      bit_idx  <= '0;
      laddr    <= '0;
      detect   <= 1'b0;
      shift    <= '0;
      req_seen <= 1'b0;
      ack_tgl  <= 1'b0;
      res      <= '0;
    end else if (lstate == L_IDLE) begin
      if (req_sync != req_seen) begin
        req_seen <= req_sync;
        laddr    <= word_addr;
        detect   <= (word_addr == 10'h0);
        lstate   <= L_CMD;
        bit_idx  <= 4'h2;
        eng.cs   <= 1'b1;
        eng.sk   <= 1'b0;
        eng.di   <= SECL_READ_CMD[2];
        half_cnt <= 8'(HALF_CYCLES - 1);
      end
    end else if (half_cnt != 8'h0) begin
      half_cnt <= half_cnt - 8'h1;
    end else begin
      half_cnt <= 8'(HALF_CYCLES - 1);
      eng.sk   <= ~eng.sk;
      if (eng.sk) begin
        unique case (lstate)
          L_CMD: begin
            if (bit_idx == 4'h0) begin
              lstate  <= L_ADDR;
              bit_idx <= detect ? SECL_ADDR_MAX - 4'h1 : res.width - 4'h1;
              eng.di  <= detect ? 1'b0 : laddr[res.width - 4'h1];
            end else begin
              bit_idx <= bit_idx - 4'h1;
              eng.di  <= SECL_READ_CMD[bit_idx[1:0] - 2'h1];
            end
          end
          L_ADDR: begin
            if (detect && !do_sync) begin
              res.width <= sent;
              lstate    <= L_DATA;
              bit_idx   <= 4'hf;
              eng.di    <= 1'b0;
              if (sent < SECL_ADDR_MIN) begin
                res.absent <= 1'b1;
                eng.cs     <= 1'b0;
                lstate     <= L_IDLE;
                ack_tgl    <= ~ack_tgl;
              end
            end else if (bit_idx == 4'h0) begin
              if (detect) begin
                res.absent <= 1'b1;
                eng.cs     <= 1'b0;
                lstate     <= L_IDLE;
                ack_tgl    <= ~ack_tgl;
              end else begin
                lstate  <= L_DATA;
                bit_idx <= 4'hf;
                eng.di  <= 1'b0;
              end
            end else begin
              bit_idx <= bit_idx - 4'h1;
              eng.di  <= laddr[bit_idx - 4'h1];
            end
          end
          L_DATA: begin
            shift <= {shift[14:0], do_sync};
            if (bit_idx == 4'h0) begin
              res.data   <= {shift[14:0], do_sync};
              res.absent <= 1'b0;
              eng.cs     <= 1'b0;
              lstate     <= L_IDLE;
              ack_tgl    <= ~ack_tgl;
            end else begin
              bit_idx <= bit_idx - 4'h1;
            end
          end
          default: lstate <= L_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // memory pins: engine while loading, software afterwards
  // ----------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_rst) begin
      ee_pins <= '0;
    end else if (busy_sync) begin
      ee_pins <= eng;
    end else begin
      ee_pins <= '{sk: sw_sync[0], cs: sw_sync[1], di: sw_sync[2]};
    end
  end

endmodule : secl_loader

// >>> src/secl_pkg.sv
// shared constants and types of the serial eeprom configuration loader
package secl_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] SECL_OFF_LCC   = 8'h00;
  localparam logic [7:0] SECL_OFF_INDEX = 8'h80;
  localparam logic [7:0] SECL_OFF_TABLE = 8'h84;

  // ----------------------------------------------------------------
  // local_config_control field positions and reset value
  // ----------------------------------------------------------------
  localparam int          SECL_LCC_CIS_SRC = 21;
  localparam int          SECL_LCC_SK      = 24;
  localparam int          SECL_LCC_CS      = 25;
  localparam int          SECL_LCC_DI      = 26;
  localparam int          SECL_LCC_DO      = 27;
  localparam int          SECL_LCC_VALID   = 28;
  localparam int          SECL_LCC_RELOAD  = 29;
  localparam logic [31:0] SECL_LCC_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // image layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  SECL_SIGNATURE = 8'hb5;
  localparam int          SECL_CONT_BIT  = 15;
  localparam int          SECL_FA_WRITE  = 11;
  localparam logic [2:0]  SECL_ZONE_END  = 3'h6;

  // ----------------------------------------------------------------
  // serial read framing: start bit then read opcode
  // ----------------------------------------------------------------
  localparam logic [2:0]  SECL_READ_CMD  = 3'h6;
  localparam logic [3:0]  SECL_ADDR_MIN  = 4'h6;
  localparam logic [3:0]  SECL_ADDR_MAX  = 4'ha;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sk;
    logic cs;
    logic di;
  } secl_pins_t;

  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } secl_byte_wr_t;

  typedef struct packed {
    logic        absent;
    logic [3:0]  width;
    logic [15:0] data;
  } secl_result_t;

  typedef enum logic [1:0] {M_REQ, M_WAIT, M_EXEC, M_DONE} secl_main_t;
  typedef enum logic [1:0] {L_IDLE, L_CMD, L_ADDR, L_DATA} secl_link_t;

endpackage : secl_pkg

// >>> testbench/secl_loader_monitor.sv
// concurrent checks on the loader's ports
`timescale 1ns/1ps
module secl_loader_monitor
  import secl_pkg::*;
(
  input wire logic          clock,
  input wire logic          reset,
  input wire logic          link_clock,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire secl_pins_t    ee_pins,
  input wire logic          ee_do,
  input wire logic          loading,
  input wire secl_byte_wr_t pci_cfg_wr,
  input wire secl_byte_wr_t func_access
);
  logic       sk_q;
  logic [4:0] bit_cnt;
  // ------------------------------------------------------------
  // link frame bit counter
  // ------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    sk_q <= ee_pins.sk;
  end
  always_ff @(posedge link_clock) begin
    if (reset || !ee_pins.cs) begin
      bit_cnt <= 5'h00;
    end else if (ee_pins.sk && !sk_q && bit_cnt != 5'h1f) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_retry_busy: assert property (@(posedge clock) disable iff (reset)
    (psel && penable && !pready && loading) |=> (pready && pslverr))
    else $error("access during download not retried");
  a_ready_pulse: assert property (@(posedge clock) disable iff (reset)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("ready not a single pulse after access");
  a_err_with_ready: assert property (@(posedge clock) disable iff (reset)
    pslverr |-> pready)
    else $error("error without ready");
  a_load_after_reset: assert property (@(posedge clock) disable iff (reset)
    $fell(reset) |-> loading)
    else $error("download not started after reset");
  a_cfg_in_load: assert property (@(posedge clock) disable iff (reset)
    $rose(pci_cfg_wr.valid) |-> $past(loading) ##1 !pci_cfg_wr.valid)
    else $error("config write outside download or too long");
  a_func_in_load: assert property (@(posedge clock) disable iff (reset)
    $rose(func_access.valid) |-> $past(loading) ##1 !func_access.valid)
    else $error("function access outside download or too long");
  a_start_bits: assert property (@(posedge link_clock) disable iff (reset)
    (ee_pins.sk && !sk_q && bit_cnt < 5'h03) |-> (ee_pins.di == (bit_cnt != 5'h02)))
    else $error("bad start or read opcode bit");
  a_di_steady: assert property (@(posedge link_clock) disable iff (reset)
    (ee_pins.sk && sk_q) |-> $stable(ee_pins.di))
    else $error("serial data moved while clock high");
endmodule : secl_loader_monitor

bind secl_loader secl_loader_monitor u_mon (
  .clock(clock), .reset(reset), .link_clock(link_clock), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_pins(ee_pins),
  .ee_do(ee_do), .loading(loading), .pci_cfg_wr(pci_cfg_wr), .func_access(func_access)
);

// >>> testbench/secl_eeprom_model.sv
// behavioural serial eeprom on the loader's memory pins
`timescale 1ns/1ps
module secl_eeprom_model
  import secl_pkg::*;
(
  input  wire secl_pins_t pins,
  input  wire logic       present,
  input  wire logic [3:0] aw,
  output logic            ee_do
);
  logic [15:0] mem [1024];
  logic [9:0]  addr, last_addr, next_addr;
  logic        drv, dout;
  int          cnt, seq_err;
  // ------------------------------------------------------------
  // frame decode and data shift
  // ------------------------------------------------------------
  initial begin
    cnt = 0;
    seq_err = 0;
    drv = 1'b0;
    dout = 1'b1;
    addr = 10'h000;
    last_addr = 10'h000;
    next_addr = 10'h000;
  end
  always @(negedge pins.cs) begin
    cnt = 0;
    drv = 1'b0;
    addr = 10'h000;
  end
  always @(posedge pins.sk) begin
    if (pins.cs && present) begin
      if (cnt >= 3 && cnt < 3 + aw) begin
        addr = {addr[8:0], pins.di};
      end
      if (cnt == 2 + aw) begin
        if (addr != 10'h000 && addr != next_addr) seq_err++;
        next_addr = addr + 10'h001;
        last_addr = addr;
        drv = 1'b1;
        dout = 1'b0;
      end else if (cnt > 2 + aw && cnt < 19 + aw) begin
        dout = mem[last_addr][18 + aw - cnt];
      end else if (cnt == 19 + aw) begin
        dout = ~dout;
      end
      cnt++;
    end
  end
  // deselected or absent: pull-up wins
  assign ee_do = (present && pins.cs && drv) ? dout : 1'b1;
endmodule : secl_eeprom_model

// >>> testbench/serial_eeprom_config_loader_tb_top.sv
// self-checking bench of the serial eeprom configuration loader
`timescale 1ns/1ps
module serial_eeprom_config_loader_tb_top
  import secl_pkg::*;
;
  typedef struct packed {
    logic [5:0]  idx;
    logic [7:0]  addr;
    logic [31:0] mask;
    logic [31:0] exp;
  } secl_row_t;
  localparam secl_row_t ROWS [7] = '{
    '{6'h00, 8'h84, 32'hffff_0000, 32'h1234_0000},
    '{6'h01, 8'h84, 32'hffff_0000, 32'h5678_0000},
    '{6'h03, 8'h84, 32'h0000_03ff, 32'h0000_025a},
    '{6'h0f, 8'h84, 32'h0000_03ff, 32'h0000_01a5},
    '{6'h00, 8'h04, 32'h0000_00ff, 32'h0000_0011},
    '{6'h00, 8'h7c, 32'hff00_0000, 32'h2200_0000},
    '{6'h00, 8'h00, 32'h1020_0000, 32'h1020_0000}};
  logic          clock, reset, link_clock, psel, penable, pwrite;
  logic          pready, pslverr, loading, ee_do, present, err;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [3:0]    aw;
  secl_pins_t    ee_pins;
  secl_byte_wr_t pci_cfg_wr, func_access;
  secl_byte_wr_t wr_q [$];
  int            err_total = 0;
  int            n_tests   = 0;
  int            cycles    = 0;

  secl_loader u_dut (
    .clock(clock), .reset(reset), .link_clock(link_clock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_pins(ee_pins),
    .ee_do(ee_do), .loading(loading), .pci_cfg_wr(pci_cfg_wr), .func_access(func_access));
  secl_eeprom_model u_ee (.pins(ee_pins), .present(present), .aw(aw), .ee_do(ee_do));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #3.3;
    forever #7.5 link_clock = ~link_clock;
  end
  // ------------------------------------------------------------
  // write capture and watchdog
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (pci_cfg_wr.valid === 1'b1) wr_q.push_back(pci_cfg_wr);
    if (func_access.valid === 1'b1) wr_q.push_back(func_access);
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check32
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic put(input logic [15:0] w []);
    for (int i = 0; i < 1024; i++) u_ee.mem[i] = 16'hffff;
    foreach (w[i]) u_ee.mem[i] = w[i];
  endtask : put
  task automatic boot(input logic [3:0] w, input logic p);
    aw = w;
    present = p;
    @(posedge clock);
    reset <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    wr_q.delete();
  endtask : boot
  task automatic wait_done();
    @(posedge clock);
    while (loading !== 1'b0) @(posedge clock);
  endtask : wait_done
  task automatic pins_chk(input logic [2:0] e);
    for (int k = 0; k < 20 && ee_pins !== e; k++) @(posedge clock);
    check32("pins", {29'h0, e}, {29'h0, ee_pins});
  endtask : pins_chk
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    put('{16'hffff});
    boot(4'h6, 1'b0);
    apb(1'b1, SECL_OFF_INDEX, 32'h3f);
    check32("busy_err", 32'h1, {31'h0, err});
    wait_done();
    check32("absent_writes", 32'h0, wr_q.size());
    apb(1'b0, SECL_OFF_LCC, 32'h0);
    check32("absent_lcc", SECL_LCC_RESET, rd & 32'hf7ff_ffff);
    apb(1'b0, SECL_OFF_INDEX, 32'h0);
    check32("index", 32'h0, rd & 32'h3f);
    put('{16'hb51e, 16'h8e5a, 16'h3da5, 16'h8411, 16'h7f22, 16'h0004, 16'h1234,
          16'h5678, 16'h8000, 16'hbd01, 16'h2c9a, 16'h0000});
    boot(4'h6, 1'b1);
    wait_done();
    check32("cfg_n", 32'h2, wr_q.size());
    check32("cfg0", 32'h0003_3d01, 32'(wr_q[0]));
    check32("cfg1", 32'h0003_2c9a, 32'(wr_q[1]));
    foreach (ROWS[i]) begin
      apb(1'b1, SECL_OFF_INDEX, {26'h0, ROWS[i].idx});
      apb(1'b0, ROWS[i].addr, 32'h0);
      check32("row", ROWS[i].exp, rd & ROWS[i].mask);
    end
    apb(1'b1, SECL_OFF_LCC, 32'h0600_0000);
    pins_chk(3'b011);
    apb(1'b1, SECL_OFF_LCC, 32'h0700_0000);
    pins_chk(3'b111);
    apb(1'b0, SECL_OFF_LCC, 32'h0);
    check32("do_bit", 32'h0800_0000, rd & 32'h0800_0000);
    apb(1'b1, SECL_OFF_LCC, 32'h0);
    pins_chk(3'b000);
    u_ee.mem[3] = 16'h8433;
    apb(1'b1, SECL_OFF_LCC, 32'h2000_0000);
    apb(1'b0, SECL_OFF_LCC, 32'h0);
    check32("reload_busy", 32'h1, {31'h0, err});
    wait_done();
    apb(1'b0, 8'h04, 32'h0);
    check32("reload_data", 32'h33, rd & 32'hff);
    apb(1'b0, 8'h88, 32'h0);
    check32("bad_addr_err", 32'h1, {31'h0, err});
    put('{16'hb501, 16'h8804, 16'h8010, 16'h8001, 16'h0000});
    for (int w = 6; w <= 10; w++) begin
      boot(w[3:0], 1'b1);
      wait_done();
      check32("fa_n", 32'h2, wr_q.size());
      check32("fa0", 32'h0003_0410, 32'(wr_q[0]));
      check32("fa1", 32'h0002_0100, 32'(wr_q[1]));
      check32("last_addr", 32'h4, {22'h0, u_ee.last_addr});
    end
    put('{16'ha51f, 16'h8e5a});
    boot(4'h8, 1'b1);
    wait_done();
    check32("bad_hdr_writes", 32'h0, wr_q.size());
    check32("bad_hdr_addr", 32'h0, {22'h0, u_ee.last_addr});
    apb(1'b0, SECL_OFF_LCC, 32'h0);
    check32("bad_hdr_valid", 32'h0, rd & 32'h1000_0000);
    check32("seq", 32'h0, u_ee.seq_err);
    finish_test();
  end
endmodule : serial_eeprom_config_loader_tb_top
